// ### inc/decoder_regs.svh
// Field positions and fixed values for the instruction decoder.
// Assumes a 32-bit instruction word delivered by the fetch stage.
`ifndef DECODER_REGS_SVH
`define DECODER_REGS_SVH

`define SEL_A_MSB    31
`define SEL_A_LSB    27
`define SEL_B_MSB    26
`define SEL_B_LSB    22
`define SEL_C_MSB    21
`define SEL_C_LSB    17
`define EXT_MSB      16
`define EXT_LSB      6
`define XCODE_MSB    10
`define XCODE_LSB    5
`define XIMM_MSB     4
`define SIMM_MSB     21
`define SIMM_LSB     6
`define JTGT_MSB     31
`define JTGT_LSB     6
`define MAJ_MSB      5
`define MAJ_LSB      0
`define PC_SEG_LSB   28
`define LINK_SEL     5'h1f
`define DEC_RST      '0

`endif

// ### inc/decoder_pkg.sv
// Types shared by the instruction decoder and its users.
// Assumes nothing beyond a SystemVerilog compiler.
package dec_pkg;

  typedef enum logic [1:0] {FMT_I = 2'h0, FMT_R = 2'h1, FMT_J = 2'h3} fmt_t;

  typedef enum logic [3:0] {
    C_NONE = 4'h0, C_JUMP = 4'h1, C_LOAD = 4'h2, C_STORE = 4'h3,
    C_BRANCH = 4'h4, C_CMP = 4'h5, C_ALU = 4'h6, C_SHIFT = 4'h7,
    C_CACHE = 4'h8, C_CTRL = 4'h9, C_SYS = 4'ha, C_CUSTOM = 4'hb
  } cls_t;

  typedef enum logic [2:0] {
    K_ALW = 3'h0, K_GE = 3'h1, K_LT = 3'h2, K_NE = 3'h3,
    K_EQ = 3'h4, K_GEU = 3'h5, K_LTU = 3'h6
  } cond_t;

  typedef enum logic [4:0] {
    A_NONE = 5'h00, A_ADD = 5'h01, A_SUB = 5'h02, A_AND = 5'h03,
    A_OR = 5'h04, A_XOR = 5'h05, A_NOR = 5'h06, A_MUL = 5'h07,
    A_MULH_SS = 5'h08, A_MULH_SU = 5'h09, A_MULH_UU = 5'h0a,
    A_DIV = 5'h0b, A_DIVU = 5'h0c, A_ROL = 5'h0d, A_ROR = 5'h0e,
    A_SLL = 5'h0f, A_SRL = 5'h10, A_SRA = 5'h11
  } alu_t;

  typedef enum logic [1:0] {S_B = 2'h0, S_H = 2'h1, S_W = 2'h2} size_t;

  typedef struct packed {
    cls_t  cls;
    cond_t cond;
    alu_t  alu;
    size_t size;
    logic  msgn;
    logic  io;
    logic  wr;
    logic  uimm;
    logic  hi;
    logic  ximm;
  } attr_t;

  typedef struct packed {
    logic        valid;
    fmt_t        fmt;
    attr_t       attr;
    logic [5:0]  major;
    logic [5:0]  xcode;
    logic [4:0]  src_a;
    logic [4:0]  src_b;
    logic        use_b;
    logic [4:0]  dest;
    logic        prev_src;
    logic        prev_dst;
    logic [31:0] imm;
    logic [31:0] target;
    logic        reserved;
  } dec_t;

  // Major codes; 0x3a carries no operation itself, the extension field decides
  localparam logic [5:0]
    M_CALL = 6'h00, M_JUMP = 6'h01, M_LD_UB = 6'h03, M_ADD_I = 6'h04, M_ST_B = 6'h05,
    M_BR_ALW = 6'h06, M_LD_SB = 6'h07, M_CMPI_GE = 6'h08, M_LD_UH = 6'h0b, M_AND_I = 6'h0c,
    M_ST_H = 6'h0d, M_BR_GE = 6'h0e, M_LD_SH = 6'h0f, M_CMPI_LT = 6'h10, M_DC_INIT_A = 6'h13,
    M_OR_I = 6'h14, M_ST_W = 6'h15, M_BR_LT = 6'h16, M_LD_W = 6'h17, M_CMPI_NE = 6'h18,
    M_DC_FLUSH_A = 6'h1b, M_XOR_I = 6'h1c, M_BR_NE = 6'h1e, M_CMPI_EQ = 6'h20,
    M_LD_UB_IO = 6'h23, M_MUL_I = 6'h24, M_ST_B_IO = 6'h25, M_BR_EQ = 6'h26,
    M_LD_SB_IO = 6'h27, M_CMPI_GEU = 6'h28, M_LD_UH_IO = 6'h2b, M_AND_HI = 6'h2c,
    M_ST_H_IO = 6'h2d, M_BR_GEU = 6'h2e, M_LD_SH_IO = 6'h2f, M_CMPI_LTU = 6'h30,
    M_CUSTOM = 6'h32, M_DC_INIT_L = 6'h33, M_OR_HI = 6'h34, M_ST_W_IO = 6'h35,
    M_BR_LTU = 6'h36, M_LD_W_IO = 6'h37, M_RD_PREV = 6'h38, M_RTYPE = 6'h3a,
    M_DC_FLUSH_L = 6'h3b, M_XOR_HI = 6'h3c;

  // Extension codes, taken from the top six bits of the extension field
  localparam logic [5:0]
    X_EXC_RET = 6'h01, X_ROL_I = 6'h02, X_ROL = 6'h03, X_PIPE_FLUSH = 6'h04, X_RET = 6'h05,
    X_NOR = 6'h06, X_MULH_UU = 6'h07, X_CMP_GE = 6'h08, X_BRK_RET = 6'h09, X_ROR = 6'h0b,
    X_IC_FLUSH = 6'h0c, X_JMP_REG = 6'h0d, X_AND = 6'h0e, X_CMP_LT = 6'h10, X_SLL_I = 6'h12,
    X_SLL = 6'h13, X_WR_PREV = 6'h14, X_OR = 6'h16, X_MULH_SU = 6'h17, X_CMP_NE = 6'h18,
    X_SRL_I = 6'h1a, X_SRL = 6'h1b, X_NEXT_PC = 6'h1c, X_CALL_REG = 6'h1d, X_XOR = 6'h1e,
    X_MULH_SS = 6'h1f, X_CMP_EQ = 6'h20, X_DIVU = 6'h24, X_DIV = 6'h25, X_CTL_RD = 6'h26,
    X_MUL = 6'h27, X_CMP_GEU = 6'h28, X_IC_INIT = 6'h29, X_TRAP = 6'h2d, X_CTL_WR = 6'h2e,
    X_CMP_LTU = 6'h30, X_ADD = 6'h31, X_BREAK = 6'h34, X_SYNC = 6'h36, X_SUB = 6'h39,
    X_SRA_I = 6'h3a, X_SRA = 6'h3b;

endpackage : dec_pkg

// ### rtl/instr_decoder.sv
// Single-stage decoder for 32-bit soft-processor instruction words.
// Assumes fetch delivers word and PC together, qualified by a valid.
`include "decoder_regs.svh"

module instr_decoder (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        fetch_valid,
  input  wire logic [31:0] fetch_word,
  input  wire logic [31:0] fetch_pc,
  output dec_pkg::dec_t    dec_r
);

  // ************************************************************
  // Field extraction
  // ************************************************************
  logic [5:0]     major;
  logic [4:0]     sel_a;
  logic [4:0]     sel_b;
  logic [4:0]     sel_c;
  logic [10:0]    ext;
  logic [5:0]     xcode;
  logic [4:0]     ximm;
  logic [15:0]    simm;
  logic [25:0]    jfield;
  dec_pkg::attr_t ma;
  dec_pkg::attr_t xa;
  logic           m_rsvd;
  logic           x_rsvd;
  dec_pkg::dec_t  dec_nxt;

  assign major  = fetch_word[`MAJ_MSB:`MAJ_LSB];
  assign sel_a  = fetch_word[`SEL_A_MSB:`SEL_A_LSB];
  assign sel_b  = fetch_word[`SEL_B_MSB:`SEL_B_LSB];
  assign sel_c  = fetch_word[`SEL_C_MSB:`SEL_C_LSB];
  assign ext    = fetch_word[`EXT_MSB:`EXT_LSB];
  assign xcode  = ext[`XCODE_MSB:`XCODE_LSB];
  assign ximm   = ext[`XIMM_MSB:0];
  assign simm   = fetch_word[`SIMM_MSB:`SIMM_LSB];
  assign jfield = fetch_word[`JTGT_MSB:`JTGT_LSB];

  // ************************************************************
  // Attribute builders
  // ************************************************************
  function automatic dec_pkg::attr_t f_base(input dec_pkg::cls_t cls);
    dec_pkg::attr_t t;
    t = '0;
    t.cls = cls;
    return t;
  endfunction : f_base

  function automatic dec_pkg::attr_t f_ld(input dec_pkg::size_t sz,
                                          input logic sgn,
                                          input logic io);
    dec_pkg::attr_t t;
    t = f_base(dec_pkg::C_LOAD);
    t.size = sz;
    t.msgn = sgn;
    t.io   = io;
    t.wr   = 1'b1;
    return t;
  endfunction : f_ld

  function automatic dec_pkg::attr_t f_st(input dec_pkg::size_t sz,
                                          input logic io);
    dec_pkg::attr_t t;
    t = f_base(dec_pkg::C_STORE);
    t.size = sz;
    t.io   = io;
    return t;
  endfunction : f_st

  function automatic dec_pkg::attr_t f_br(input dec_pkg::cond_t k);
    dec_pkg::attr_t t;
    t = f_base(dec_pkg::C_BRANCH);
    t.cond = k;
    return t;
  endfunction : f_br

  function automatic dec_pkg::attr_t f_cmp(input dec_pkg::cond_t k,
                                           input logic u);
    dec_pkg::attr_t t;
    t = f_base(dec_pkg::C_CMP);
    t.cond = k;
    t.uimm = u;
    t.wr   = 1'b1;
    return t;
  endfunction : f_cmp

  function automatic dec_pkg::attr_t f_alu(input dec_pkg::alu_t a,
                                           input logic u,
                                           input logic hi);
    dec_pkg::attr_t t;
    t = f_base(dec_pkg::C_ALU);
    t.alu  = a;
    t.uimm = u;
    t.hi   = hi;
    t.wr   = 1'b1;
    return t;
  endfunction : f_alu

  function automatic dec_pkg::attr_t f_sh(input dec_pkg::alu_t a,
                                          input logic im);
    dec_pkg::attr_t t;
    t = f_base(dec_pkg::C_SHIFT);
    t.alu  = a;
    t.ximm = im;
    t.wr   = 1'b1;
    return t;
  endfunction : f_sh

  function automatic dec_pkg::attr_t f_wr(input dec_pkg::cls_t cls);
    dec_pkg::attr_t t;
    t = f_base(cls);
    t.wr = 1'b1;
    return t;
  endfunction : f_wr

  // ************************************************************
  // Major code decode
  // ************************************************************
  always_comb begin : major_dec
    ma     = f_base(dec_pkg::C_NONE);
    m_rsvd = 1'b0;
    case (major)
      dec_pkg::M_CALL:     ma = f_wr(dec_pkg::C_JUMP);
      dec_pkg::M_JUMP:     ma = f_base(dec_pkg::C_JUMP);
      dec_pkg::M_LD_UB:    ma = f_ld(dec_pkg::S_B, 1'b0, 1'b0);
      dec_pkg::M_LD_SB:    ma = f_ld(dec_pkg::S_B, 1'b1, 1'b0);
      dec_pkg::M_LD_UH:    ma = f_ld(dec_pkg::S_H, 1'b0, 1'b0);
      dec_pkg::M_LD_SH:    ma = f_ld(dec_pkg::S_H, 1'b1, 1'b0);
      dec_pkg::M_LD_W:     ma = f_ld(dec_pkg::S_W, 1'b1, 1'b0);
      dec_pkg::M_LD_UB_IO: ma = f_ld(dec_pkg::S_B, 1'b0, 1'b1);
      dec_pkg::M_LD_SB_IO: ma = f_ld(dec_pkg::S_B, 1'b1, 1'b1);
      dec_pkg::M_LD_UH_IO: ma = f_ld(dec_pkg::S_H, 1'b0, 1'b1);
      dec_pkg::M_LD_SH_IO: ma = f_ld(dec_pkg::S_H, 1'b1, 1'b1);
      dec_pkg::M_LD_W_IO:  ma = f_ld(dec_pkg::S_W, 1'b1, 1'b1);
      dec_pkg::M_ST_B:     ma = f_st(dec_pkg::S_B, 1'b0);
      dec_pkg::M_ST_H:     ma = f_st(dec_pkg::S_H, 1'b0);
      dec_pkg::M_ST_W:     ma = f_st(dec_pkg::S_W, 1'b0);
      dec_pkg::M_ST_B_IO:  ma = f_st(dec_pkg::S_B, 1'b1);
      dec_pkg::M_ST_H_IO:  ma = f_st(dec_pkg::S_H, 1'b1);
      dec_pkg::M_ST_W_IO:  ma = f_st(dec_pkg::S_W, 1'b1);
      dec_pkg::M_BR_ALW:   ma = f_br(dec_pkg::K_ALW);
      dec_pkg::M_BR_LT:    ma = f_br(dec_pkg::K_LT);
      dec_pkg::M_BR_EQ:    ma = f_br(dec_pkg::K_EQ);
      dec_pkg::M_BR_LTU:   ma = f_br(dec_pkg::K_LTU);
      dec_pkg::M_BR_GE:    ma = f_br(dec_pkg::K_GE);
      dec_pkg::M_BR_NE:    ma = f_br(dec_pkg::K_NE);
      dec_pkg::M_BR_GEU:   ma = f_br(dec_pkg::K_GEU);
      dec_pkg::M_CMPI_GE:  ma = f_cmp(dec_pkg::K_GE, 1'b0);
      dec_pkg::M_CMPI_LT:  ma = f_cmp(dec_pkg::K_LT, 1'b0);
      dec_pkg::M_CMPI_NE:  ma = f_cmp(dec_pkg::K_NE, 1'b0);
      dec_pkg::M_CMPI_EQ:  ma = f_cmp(dec_pkg::K_EQ, 1'b0);
      dec_pkg::M_CMPI_GEU: ma = f_cmp(dec_pkg::K_GEU, 1'b1);
      dec_pkg::M_CMPI_LTU: ma = f_cmp(dec_pkg::K_LTU, 1'b1);
      dec_pkg::M_ADD_I:    ma = f_alu(dec_pkg::A_ADD, 1'b0, 1'b0);
      dec_pkg::M_MUL_I:    ma = f_alu(dec_pkg::A_MUL, 1'b0, 1'b0);
      dec_pkg::M_AND_I:    ma = f_alu(dec_pkg::A_AND, 1'b1, 1'b0);
      dec_pkg::M_OR_I:     ma = f_alu(dec_pkg::A_OR, 1'b1, 1'b0);
      dec_pkg::M_XOR_I:    ma = f_alu(dec_pkg::A_XOR, 1'b1, 1'b0);
      dec_pkg::M_AND_HI:   ma = f_alu(dec_pkg::A_AND, 1'b1, 1'b1);
      dec_pkg::M_OR_HI:    ma = f_alu(dec_pkg::A_OR, 1'b1, 1'b1);
      dec_pkg::M_XOR_HI:   ma = f_alu(dec_pkg::A_XOR, 1'b1, 1'b1);
      dec_pkg::M_DC_INIT_A,
      dec_pkg::M_DC_INIT_L,
      dec_pkg::M_DC_FLUSH_A,
      dec_pkg::M_DC_FLUSH_L: ma = f_base(dec_pkg::C_CACHE);
      dec_pkg::M_CUSTOM:   ma = f_wr(dec_pkg::C_CUSTOM);
      dec_pkg::M_RD_PREV:  ma = f_alu(dec_pkg::A_ADD, 1'b0, 1'b0);
      dec_pkg::M_RTYPE:    ma = f_base(dec_pkg::C_NONE);
      default:             m_rsvd = 1'b1;
    endcase
  end

  // ************************************************************
  // Extension code decode
  // ************************************************************
  always_comb begin : ext_dec
    xa     = f_base(dec_pkg::C_NONE);
    x_rsvd = 1'b0;
    case (xcode)
      dec_pkg::X_CMP_GE:   xa = f_cmp(dec_pkg::K_GE, 1'b0);
      dec_pkg::X_CMP_LT:   xa = f_cmp(dec_pkg::K_LT, 1'b0);
      dec_pkg::X_CMP_NE:   xa = f_cmp(dec_pkg::K_NE, 1'b0);
      dec_pkg::X_CMP_EQ:   xa = f_cmp(dec_pkg::K_EQ, 1'b0);
      dec_pkg::X_CMP_GEU:  xa = f_cmp(dec_pkg::K_GEU, 1'b0);
      dec_pkg::X_CMP_LTU:  xa = f_cmp(dec_pkg::K_LTU, 1'b0);
      dec_pkg::X_ROL_I:    xa = f_sh(dec_pkg::A_ROL, 1'b1);
      dec_pkg::X_ROL:      xa = f_sh(dec_pkg::A_ROL, 1'b0);
      dec_pkg::X_ROR:      xa = f_sh(dec_pkg::A_ROR, 1'b0);
      dec_pkg::X_SLL_I:    xa = f_sh(dec_pkg::A_SLL, 1'b1);
      dec_pkg::X_SLL:      xa = f_sh(dec_pkg::A_SLL, 1'b0);
      dec_pkg::X_SRL_I:    xa = f_sh(dec_pkg::A_SRL, 1'b1);
      dec_pkg::X_SRL:      xa = f_sh(dec_pkg::A_SRL, 1'b0);
      dec_pkg::X_SRA_I:    xa = f_sh(dec_pkg::A_SRA, 1'b1);
      dec_pkg::X_SRA:      xa = f_sh(dec_pkg::A_SRA, 1'b0);
      dec_pkg::X_ADD:      xa = f_alu(dec_pkg::A_ADD, 1'b0, 1'b0);
      dec_pkg::X_SUB:      xa = f_alu(dec_pkg::A_SUB, 1'b0, 1'b0);
      dec_pkg::X_AND:      xa = f_alu(dec_pkg::A_AND, 1'b0, 1'b0);
      dec_pkg::X_OR:       xa = f_alu(dec_pkg::A_OR, 1'b0, 1'b0);
      dec_pkg::X_XOR:      xa = f_alu(dec_pkg::A_XOR, 1'b0, 1'b0);
      dec_pkg::X_NOR:      xa = f_alu(dec_pkg::A_NOR, 1'b0, 1'b0);
      dec_pkg::X_MUL:      xa = f_alu(dec_pkg::A_MUL, 1'b0, 1'b0);
      dec_pkg::X_MULH_UU:  xa = f_alu(dec_pkg::A_MULH_UU, 1'b0, 1'b0);
      dec_pkg::X_MULH_SU:  xa = f_alu(dec_pkg::A_MULH_SU, 1'b0, 1'b0);
      dec_pkg::X_MULH_SS:  xa = f_alu(dec_pkg::A_MULH_SS, 1'b0, 1'b0);
      dec_pkg::X_DIV:      xa = f_alu(dec_pkg::A_DIV, 1'b0, 1'b0);
      dec_pkg::X_DIVU:     xa = f_alu(dec_pkg::A_DIVU, 1'b0, 1'b0);
      dec_pkg::X_JMP_REG,
      dec_pkg::X_RET,
      dec_pkg::X_EXC_RET,
      dec_pkg::X_BRK_RET:  xa = f_base(dec_pkg::C_CTRL);
      dec_pkg::X_CALL_REG: xa = f_wr(dec_pkg::C_CTRL);
      dec_pkg::X_NEXT_PC:  xa = f_wr(dec_pkg::C_CTRL);
      dec_pkg::X_TRAP,
      dec_pkg::X_BREAK: begin
        xa      = f_base(dec_pkg::C_CTRL);
        xa.ximm = 1'b1;
      end
      dec_pkg::X_CTL_RD:   xa = f_wr(dec_pkg::C_SYS);
      dec_pkg::X_WR_PREV:  xa = f_wr(dec_pkg::C_SYS);
      dec_pkg::X_CTL_WR,
      dec_pkg::X_PIPE_FLUSH,
      dec_pkg::X_SYNC:     xa = f_base(dec_pkg::C_SYS);
      dec_pkg::X_IC_FLUSH,
      dec_pkg::X_IC_INIT:  xa = f_base(dec_pkg::C_SYS);
      default:             x_rsvd = 1'b1;
    endcase
    // Unused small-immediate bits must be zero, else treat as reserved
    if (!xa.ximm && (ximm != 5'h00)) begin
      x_rsvd = 1'b1;
    end
  end

  // ************************************************************
  // Operand and immediate assembly
  // ************************************************************
  always_comb begin : assemble
    dec_nxt       = `DEC_RST;
    dec_nxt.valid = fetch_valid;
    dec_nxt.major = major;
    dec_nxt.xcode = xcode;
    if (major == dec_pkg::M_RTYPE) begin
      dec_nxt.fmt      = dec_pkg::FMT_R;
      dec_nxt.attr     = xa;
      dec_nxt.src_a    = sel_a;
      dec_nxt.src_b    = sel_b;
      dec_nxt.use_b    = 1'b1;
      dec_nxt.dest     = sel_c;
      dec_nxt.prev_dst = (xcode == dec_pkg::X_WR_PREV);
      dec_nxt.imm      = {27'h0, ximm};
      dec_nxt.reserved = x_rsvd;
      if (xcode == dec_pkg::X_CALL_REG) begin
        dec_nxt.dest = `LINK_SEL;
      end
    end else if (major == dec_pkg::M_CALL || major == dec_pkg::M_JUMP) begin
      dec_nxt.fmt    = dec_pkg::FMT_J;
      dec_nxt.attr   = ma;
      dec_nxt.dest   = `LINK_SEL;
      dec_nxt.imm    = {6'h00, jfield};
      // Top PC bits kept, so reach is one aligned 256-MB segment
      dec_nxt.target = {fetch_pc[31:`PC_SEG_LSB], jfield, 2'b00};
    end else if (major == dec_pkg::M_CUSTOM) begin
      // Custom op carries register fields and passes extension through
      dec_nxt.fmt   = dec_pkg::FMT_R;
      dec_nxt.attr  = ma;
      dec_nxt.src_a = sel_a;
      dec_nxt.src_b = sel_b;
      dec_nxt.use_b = 1'b1;
      dec_nxt.dest  = sel_c;
      dec_nxt.imm   = {21'h0, ext};
    end else begin
      dec_nxt.fmt      = dec_pkg::FMT_I;
      dec_nxt.attr     = ma;
      dec_nxt.src_a    = sel_a;
      dec_nxt.src_b    = sel_b;
      dec_nxt.dest     = sel_b;
      dec_nxt.prev_src = (major == dec_pkg::M_RD_PREV);
      dec_nxt.reserved = m_rsvd;
      // Stores and branches read the second selector instead of writing it
      dec_nxt.use_b = (ma.cls == dec_pkg::C_STORE) ||
                      (ma.cls == dec_pkg::C_BRANCH);
      if (ma.hi) begin
        dec_nxt.imm = {simm, 16'h0000};
      end else if (ma.uimm) begin
        dec_nxt.imm = {16'h0000, simm};
      end else begin
        dec_nxt.imm = {{16{simm[15]}}, simm};
      end
    end
    // A reserved word must never retire a register write
    if (dec_nxt.reserved) begin
      dec_nxt.attr.wr = 1'b0;
    end
  end

  // ************************************************************
  // Output register
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_r <= `DEC_RST;
    end else begin
      dec_r <= dec_nxt;
    end
  end

endmodule : instr_decoder

// ### sim/decoder_chk_sva.sv
// Concurrent checks tying each registered decode to the word fetched one edge before.
// Assumes one clock domain and an asynchronous active-low reset.
// ****************************************
// Checker
// ****************************************
module decoder_chk (
  input wire logic          sys_clk,
  input wire logic          rst_n,
  input wire logic          fetch_valid,
  input wire logic [31:0]   fetch_word,
  input wire logic [31:0]   fetch_pc,
  input wire dec_pkg::dec_t dec_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        armed_r;
  logic        v_q;
  logic [31:0] w_q;
  logic [31:0] pc_q;
  logic [5:0]  maj;
  // Output still shows reset zeros at the first edge after release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    v_q  <= fetch_valid;
    w_q  <= fetch_word;
    pc_q <= fetch_pc;
  end
  assign maj = w_q[5:0];
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_major_copy: assert property (armed_r |-> dec_r.major == maj && dec_r.valid == v_q)
    else $error("major field or valid not carried");
  a_jump_target: assert property (armed_r && maj[5:1] == 5'h00 |->
    dec_r.fmt == dec_pkg::FMT_J && dec_r.target == {pc_q[31:28], w_q[31:6], 2'b00})
    else $error("jump target wrong");
  a_call_link: assert property (armed_r && maj == 6'h00 |-> dec_r.dest == 5'h1f
    && dec_r.attr.wr) else $error("call does not write link");
  a_rtype_ext: assert property (armed_r && maj == 6'h3a |-> dec_r.fmt == dec_pkg::FMT_R
    && dec_r.xcode == w_q[16:11]) else $error("register format code wrong");
  a_rtype_regs: assert property (armed_r && maj == 6'h3a && w_q[16:6] == 11'h620
    |-> dec_r.src_a == w_q[31:27] && dec_r.src_b == w_q[26:22] && dec_r.dest == w_q[21:17]
    && dec_r.attr.wr && !dec_r.reserved) else $error("register operands wrong");
  a_unused_ext: assert property (armed_r && maj == 6'h3a && w_q[16:11] == 6'h31
    && w_q[10:6] != 5'h00 |-> dec_r.reserved && !dec_r.attr.wr) else $error("unused bits kept");
  a_addi_sext: assert property (armed_r && maj == 6'h04 |-> dec_r.imm == {{16{w_q[21]}},
    w_q[21:6]} && dec_r.src_a == w_q[31:27] && dec_r.dest == w_q[26:22])
    else $error("add immediate decode wrong");
  a_logic_zext: assert property (armed_r && maj inside {6'h0c, 6'h14, 6'h1c, 6'h28, 6'h30}
    |-> dec_r.imm == {16'h0000, w_q[21:6]}) else $error("immediate not zero-extended");
  a_high_imm: assert property (armed_r && maj inside {6'h2c, 6'h34, 6'h3c}
    |-> dec_r.imm == {w_q[21:6], 16'h0000}) else $error("high-half immediate wrong");
  a_reserved_op: assert property (armed_r && maj inside {6'h02, 6'h09, 6'h0a, 6'h11, 6'h12,
    6'h19, 6'h1a, 6'h1d, 6'h1f, 6'h21, 6'h22, 6'h29, 6'h2a, 6'h31, 6'h39, 6'h3d, 6'h3e, 6'h3f}
    |-> dec_r.reserved && !dec_r.attr.wr && dec_r.attr.cls == dec_pkg::C_NONE)
    else $error("reserved major not flagged");
endmodule : decoder_chk

bind instr_decoder decoder_chk decoder_chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .fetch_valid(fetch_valid), .fetch_word(fetch_word), .fetch_pc(fetch_pc), .dec_r(dec_r));

// ### sim/fetch_model.sv
// Fetch stage model: hands the decoder one word and its address per request.
// Assumes the bench calls issue from one process only.
// ****************************************
// Fetch model
// ****************************************
module fetch_model (
  input wire logic    sys_clk,
  output logic        fetch_valid,
  output logic [31:0] fetch_word,
  output logic [31:0] fetch_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    fetch_valid = 1'b0;
    fetch_word  = 32'h00000000;
    fetch_pc    = 32'h00000000;
  end
  // Idle word is the inverse so a stale word never looks held
  task automatic issue(input logic [31:0] w, input logic [31:0] pc);
    @(posedge sys_clk);
    fetch_valid <= 1'b1;
    fetch_word  <= w;
    fetch_pc    <= pc;
    @(posedge sys_clk);
    fetch_valid <= 1'b0;
    fetch_word  <= ~w;
    fetch_pc    <= ~pc;
    #1;
  endtask : issue
endmodule : fetch_model

// ### sim/tb_top.sv
// Self-checking bench for the instruction decoder: field layout, codes, reserved values.
// Assumes the fetch model in its own file and the bound checker.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic          sys_clk;
  logic          rst_n;
  logic          fetch_valid;
  logic [31:0]   fetch_word;
  logic [31:0]   fetch_pc;
  dec_pkg::dec_t dec_r;
  int            bad_count = 0;
  int            n_checks = 0;
  int            cyc = 0;
  // ****************************************
  // Code tables
  // ****************************************
  // Kind in the top two bits: 0 signed, 1 zero-extended, 2 high half
  localparam logic [7:0] itab [14] = '{8'h04, 8'h24, 8'h10, 8'h08, 8'h20, 8'h18, 8'h4c,
    8'h54, 8'h5c, 8'h68, 8'h70, 8'hac, 8'hb4, 8'hbc};
  // Code, class, then condition or operation
  localparam logic [15:0] mtab [42] = '{16'h0320, 16'h0720, 16'h0b20, 16'h0f20, 16'h1720,
    16'h2320, 16'h2720, 16'h2b20, 16'h2f20, 16'h3720, 16'h0530, 16'h0d30, 16'h1530, 16'h2530,
    16'h2d30, 16'h3530, 16'h0640, 16'h1642, 16'h2644, 16'h3646, 16'h0e41, 16'h1e43, 16'h2e45,
    16'h0851, 16'h1052, 16'h1853, 16'h2054, 16'h2855, 16'h3056, 16'h0461, 16'h2467, 16'h0c63,
    16'h1464, 16'h1c65, 16'h2c63, 16'h3464, 16'h3c65, 16'h1380, 16'h3380, 16'h1b80, 16'h3b80,
    16'h32b0};
  localparam logic [19:0] xtab [42] = '{20'h08501, 20'h10502, 20'h18503, 20'h20504,
    20'h28505, 20'h30506, 20'h0270d, 20'h0370d, 20'h0b70e, 20'h1270f, 20'h1370f, 20'h1a710,
    20'h1b710, 20'h3a711, 20'h3b711, 20'h31601, 20'h39602, 20'h0e603, 20'h16604, 20'h1e605,
    20'h06606, 20'h27607, 20'h0760a, 20'h17609, 20'h1f608, 20'h2560b, 20'h2460c, 20'h0d900,
    20'h1d900, 20'h05900, 20'h01900, 20'h09900, 20'h1c900, 20'h2d900, 20'h34900, 20'h26a00,
    20'h2ea00, 20'h14a00, 20'h04a00, 20'h0ca00, 20'h29a00, 20'h36a00};
  localparam logic [5:0] rtab [40] = '{6'h02, 6'h09, 6'h0a, 6'h11, 6'h12, 6'h19, 6'h1a, 6'h1d,
    6'h1f, 6'h21, 6'h22, 6'h29, 6'h2a, 6'h31, 6'h39, 6'h3d, 6'h3e, 6'h3f, 6'h00, 6'h0a, 6'h0f,
    6'h11, 6'h15, 6'h19, 6'h21, 6'h22, 6'h23, 6'h2a, 6'h2b, 6'h2c, 6'h2f, 6'h32, 6'h33, 6'h35,
    6'h37, 6'h38, 6'h3c, 6'h3d, 6'h3e, 6'h3f};
  fetch_model fetch_model_i (.sys_clk(sys_clk), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_pc(fetch_pc));
  instr_decoder instr_decoder_i (.sys_clk(sys_clk), .rst_n(rst_n), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_pc(fetch_pc), .dec_r(dec_r));
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_itype();
    logic [31:0] x;
    foreach (itab[i]) begin
      x = (itab[i][7:6] == 2'h2) ? 32'h8a5c0000 : itab[i][6] ? 32'h00008a5c : 32'hffff8a5c;
      fetch_model_i.issue({5'h03, 5'h1c, 16'h8a5c, itab[i][5:0]}, 32'h00000000);
      chk(dec_r.imm, x);
      chk(32'({dec_r.src_a, dec_r.dest, dec_r.fmt}), 32'h000001f0);
    end
    $display("test itype done");
  endtask : t_itype
  task automatic t_jump();
    for (int j = 0; j < 2; j++) begin
      fetch_model_i.issue({26'h2abcdef, 5'h00, j[0]}, 32'hd0001234);
      chk(dec_r.target, 32'hdaaf37bc);
      chk(32'({dec_r.fmt, dec_r.attr.wr, dec_r.dest}), 32'({2'h3, ~j[0], 5'h1f}));
    end
    fetch_model_i.issue(32'hffffffc0, 32'h7fffffff);
    chk(dec_r.target, 32'h7fffffff & 32'hfffffffc);
    $display("test jump done");
  endtask : t_jump
  task automatic t_rtype();
    fetch_model_i.issue({5'h01, 5'h02, 5'h03, 6'h31, 5'h00, 6'h3a}, 32'h00000000);
    chk(32'({dec_r.src_a, dec_r.src_b, dec_r.dest, dec_r.fmt}), 32'h0000110d);
    chk(32'({dec_r.xcode, dec_r.attr.wr, dec_r.reserved}), 32'h000000c6);
    fetch_model_i.issue({5'h01, 5'h02, 5'h03, 6'h12, 5'h1b, 6'h3a}, 32'h00000000);
    chk(dec_r.imm, 32'h0000001b);
    fetch_model_i.issue({5'h01, 5'h02, 5'h03, 6'h31, 5'h04, 6'h3a}, 32'h00000000);
    chk(32'({dec_r.reserved, dec_r.attr.wr}), 32'h00000002);
    fetch_model_i.issue({5'h01, 5'h02, 16'h0000, 6'h38}, 32'h00000000);
    chk(32'({dec_r.prev_src, dec_r.reserved}), 32'h00000002);
    fetch_model_i.issue({5'h01, 5'h02, 5'h03, 6'h14, 5'h00, 6'h3a}, 32'h00000000);
    chk(32'(dec_r.prev_dst), 32'h00000001);
    $display("test rtype done");
  endtask : t_rtype
  task automatic t_codes();
    logic [15:0] m;
    logic [19:0] x;
    foreach (mtab[i]) begin
      m = mtab[i];
      fetch_model_i.issue({5'h04, 5'h05, 16'h0120, m[13:8]}, 32'h00000000);
      chk(32'({dec_r.attr.cls, dec_r.reserved}), 32'({m[7:4], 1'b0}));
      chk(32'(dec_r.use_b), 32'(m[7:4] inside {4'h3, 4'h4, 4'hb}));
      if (m[7:4] inside {4'h4, 4'h5}) chk(32'(dec_r.attr.cond), 32'(m[2:0]));
      if (m[7:4] == 4'h6) chk(32'(dec_r.attr.alu), 32'(m[3:0]));
      if (m[7:5] == 3'h1) chk(32'({dec_r.attr.io, dec_r.attr.size}), 32'(m[13:11]));
      if (m[7:4] == 4'h2 && !m[12]) chk(32'(dec_r.attr.msgn), 32'(m[10]));
    end
    foreach (xtab[i]) begin
      x = xtab[i];
      fetch_model_i.issue({5'h01, 5'h02, 5'h03, x[17:12], 5'h00, 6'h3a}, 32'h00000000);
      chk(32'({dec_r.attr.cls, dec_r.reserved, dec_r.use_b}), 32'({x[11:8], 2'b01}));
      chk(32'(dec_r.dest), (x[17:12] == 6'h1d) ? 32'h0000001f : 32'h00000003);
      if (x[11:8] == 4'h5) chk(32'(dec_r.attr.cond), 32'(x[2:0]));
      if (x[11:9] == 3'h3) chk(32'(dec_r.attr.alu), 32'(x[4:0]));
    end
    $display("test codes done");
  endtask : t_codes
  task automatic t_reserved();
    foreach (rtab[i]) begin
      if (i < 18) fetch_model_i.issue({5'h01, 5'h02, 16'h0000, rtab[i]}, 32'h00000000);
      else fetch_model_i.issue({5'h01, 5'h02, 5'h03, rtab[i], 5'h00, 6'h3a}, 32'h00000000);
      chk(32'({dec_r.reserved, dec_r.attr.wr, dec_r.attr.cls}), 32'h00000020);
    end
    $display("test reserved done");
  endtask : t_reserved
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      $display("FAIL %0t: run did not finish", $time);
      give_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_itype();
    t_jump();
    t_rtype();
    t_codes();
    t_reserved();
    give_verdict();
  end
endmodule : tb_top
